// ---- brs_pkg.sv ----
// Constants and types for the boot reset sequencer.
// Assumes a single 125 MHz clock taken from the primary clock input.
// Operation
// R1 - Hold everything in reset until supply good
// R2 - System clock comes from primary clock input
// R3 - Strap selects crystal or external clock source
// R4 - Crystal: extend reset until oscillator settles
// R5 - External clock: release without settling delay
// R6 - All PLLs disabled on leaving reset
// R7 - All module clocks ungated, undivided at release
// R8 - First fetch at virtual address 0xa0000000
// R9 - Fixed segment untranslated, uncached, maps to zero
// R10 - Physical zero routes to static select zero
// R11 - Internal reset released synchronously on one edge
package brs_pkg;
    localparam int          BRS_CLK_MHZ       = 125;
    localparam int          BRS_SETTLE_US     = 1000;
    localparam int          BRS_SETTLE_CYC    = BRS_SETTLE_US * BRS_CLK_MHZ;
    localparam int          BRS_CNT_W         = 24;
    localparam int          BRS_NUM_PLL       = 2;
    localparam int          BRS_NUM_MOD       = 16;
    localparam int          BRS_DIV_W         = 4;
    localparam logic [31:0] BRS_RESET_VADDR   = 32'ha000_0000;
    localparam logic [31:0] BRS_SEG_VBASE     = 32'ha000_0000;
    localparam logic [31:0] BRS_SEG_SIZE      = 32'h2000_0000;
    localparam logic [31:0] BRS_PHYS_BASE     = 32'h0000_0000;
    localparam logic [31:0] BRS_SEL0_SIZE     = 32'h0400_0000;
    localparam logic        BRS_STRAP_CRYSTAL = 1'b0;

    typedef enum logic [1:0] {
        BRS_POR    = 2'b00,
        BRS_SETTLE = 2'b01,
        BRS_RUN    = 2'b11
    } brs_state_t;

    typedef struct packed {
        logic [BRS_NUM_PLL-1:0]           pll_en;
        logic [BRS_NUM_MOD-1:0]           clk_gate_en;
        logic [BRS_NUM_MOD*BRS_DIV_W-1:0] clk_div;
    } brs_clk_cfg_t;

    typedef struct packed {
        logic [31:0] vaddr;
        logic [31:0] paddr;
        logic        uncached;
        logic        untranslated;
        logic        sel_zero;
    } brs_fetch_t;
endpackage : brs_pkg

// ---- brs_addr_map.sv ----
// Fixed-segment address translation and boot chip-select decode.
// Assumes the virtual address is held stable by the fetch logic.
`timescale 1ns/1ps
module brs_addr_map (
    // Address in
    input  wire logic [31:0]        vaddr,
    // Translated fetch
    output brs_pkg::brs_fetch_t     fetch
);
    import brs_pkg::*;

    logic        in_seg;
    logic [31:0] paddr;

    // Fixed segment bypasses translation and caching
    assign in_seg = (vaddr >= BRS_SEG_VBASE) &&
                    ((vaddr - BRS_SEG_VBASE) < BRS_SEG_SIZE); // [R9]
    assign paddr  = in_seg ? (vaddr - BRS_SEG_VBASE + BRS_PHYS_BASE)
                           : vaddr; // [R9]

    always_comb begin
        fetch              = '0;
        fetch.vaddr        = vaddr;
        fetch.paddr        = paddr;
        fetch.uncached     = in_seg; // [R9]
        fetch.untranslated = in_seg; // [R9]
        fetch.sel_zero     = (paddr >= BRS_PHYS_BASE) &&
                             ((paddr - BRS_PHYS_BASE) < BRS_SEL0_SIZE); // [R10]
    end
endmodule : brs_addr_map

// ---- brs_sequencer.sv ----
// Power-up reset sequencer: holds reset, waits for a crystal to settle,
// releases a synchronous system reset and presents boot defaults.
// Assumes clk is the primary clock input and rst follows the
// power-on detector; strap and supply flag are asynchronous pins.
`timescale 1ns/1ps
module brs_sequencer #(
    parameter int SETTLE_CYC = brs_pkg::BRS_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 clk_en,
    // Pins
    input  wire logic                 supply_good,
    input  wire logic                 oscillator_select_strap,
    // Fetch address from processor
    input  wire logic [31:0]          fetch_vaddr,
    // Reset, clock and boot vector outputs
    output logic                      sys_rst,
    output logic                      sys_clk_sel_primary,
    output brs_pkg::brs_clk_cfg_t     clk_cfg,
    output logic [31:0]               boot_pc,
    output logic                      crystal_mode,
    // Fetch decode
    output brs_pkg::brs_fetch_t       fetch
);
    import brs_pkg::*;

    logic                 sup_s1_q;
    logic                 sup_s2_q;
    logic                 strap_s1_q;
    logic                 strap_s2_q;
    logic                 crystal_q;
    brs_state_t           state_q;
    brs_state_t           state_d;
    logic [BRS_CNT_W-1:0] cnt_q;
    logic                 rst_q;
    logic [31:0]          pc_q;
    logic                 pll_q [BRS_NUM_PLL];
    logic                 gate_q [BRS_NUM_MOD];
    logic [BRS_DIV_W-1:0] div_q [BRS_NUM_MOD];
    brs_clk_cfg_t         cfg_w;
    logic                 settled;

    // Two-stage synchronisers for the pins
    always_ff @(posedge clk) begin
        if (rst) begin
            sup_s1_q   <= 1'b0;
            sup_s2_q   <= 1'b0;
            strap_s1_q <= 1'b1;
            strap_s2_q <= 1'b1;
        end else if (clk_en) begin
            sup_s1_q   <= supply_good;
            sup_s2_q   <= sup_s1_q;
            strap_s1_q <= oscillator_select_strap;
            strap_s2_q <= strap_s1_q;
        end
    end

    // Strap is captured while still held in reset
    always_ff @(posedge clk) begin
        if (rst) begin
            crystal_q <= 1'b0;
        end else if (clk_en && state_q == BRS_POR) begin
            crystal_q <= (strap_s2_q == BRS_STRAP_CRYSTAL); // [R3]
        end
    end

    assign settled = (cnt_q >= BRS_CNT_W'(SETTLE_CYC - 1));

    always_comb begin
        state_d = state_q;
        case (state_q)
            BRS_POR: begin
                if (sup_s2_q) begin // [R1]
                    state_d = (strap_s2_q == BRS_STRAP_CRYSTAL)
                              ? BRS_SETTLE : BRS_RUN; // [R4] [R5]
                end
            end
            BRS_SETTLE: begin
                if (settled) begin
                    state_d = BRS_RUN; // [R4]
                end
            end
            BRS_RUN: begin
                state_d = BRS_RUN;
            end
            default: begin
                state_d = BRS_POR;
            end
        endcase
        if (!sup_s2_q) begin
            state_d = BRS_POR; // [R1]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= BRS_POR;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // Settling counter runs only in the crystal wait
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            if (state_q == BRS_SETTLE && !settled) begin
                cnt_q <= cnt_q + 1'b1; // [R4]
            end else if (state_q != BRS_SETTLE) begin
                cnt_q <= '0;
            end
        end
    end

    // Registered reset drops on one clock edge for all modules
    always_ff @(posedge clk) begin
        if (rst) begin
            rst_q <= 1'b1;
        end else if (clk_en) begin
            rst_q <= (state_d != BRS_RUN); // [R1] [R11]
        end
    end

    // Boot vector reloads on every clk_en cycle spent in reset
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_q <= BRS_RESET_VADDR;
        end else if (clk_en && rst_q) begin
            pc_q <= BRS_RESET_VADDR; // [R8]
        end
    end

    // PLLs stay off until boot code turns them on
    for (genvar p = 0; p < BRS_NUM_PLL; p++) begin : g_pll
        always_ff @(posedge clk) begin
            if (rst) begin
                pll_q[p] <= 1'b0;
            end else if (clk_en && rst_q) begin
                pll_q[p] <= 1'b0; // [R6]
            end
        end
    end

    // Every module clock leaves reset running and undivided
    for (genvar m = 0; m < BRS_NUM_MOD; m++) begin : g_mod
        always_ff @(posedge clk) begin
            if (rst) begin
                gate_q[m] <= 1'b0;
                div_q[m]  <= '0;
            end else if (clk_en && rst_q) begin
                gate_q[m] <= 1'b1; // [R7]
                div_q[m]  <= '0; // [R7]
            end
        end
    end

    // Gather the per-module defaults into the carrier
    always_comb begin
        cfg_w = '0;
        for (int i = 0; i < BRS_NUM_PLL; i++) begin
            cfg_w.pll_en[i] = pll_q[i];
        end
        for (int i = 0; i < BRS_NUM_MOD; i++) begin
            cfg_w.clk_gate_en[i]                    = gate_q[i];
            cfg_w.clk_div[i*BRS_DIV_W +: BRS_DIV_W] = div_q[i];
        end
    end

    brs_addr_map u_map (
        .vaddr (fetch_vaddr),
        .fetch (fetch)
    );

    assign sys_rst             = rst_q;
    assign sys_clk_sel_primary = 1'b1; // [R2]
    assign clk_cfg             = cfg_w;
    assign boot_pc             = pc_q;
    assign crystal_mode        = crystal_q;
endmodule : brs_sequencer

// ---- brs_checker.sv ----
// Port assertions for the boot reset sequencer.
// Assumes clk_en stays high around supply edges.
`timescale 1ns/1ps
module brs_checker #(
    parameter int SETTLE_CYC = 8
) (
    // Clock, reset and pins
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  supply_good,
    input wire logic                  oscillator_select_strap,
    input wire logic [31:0]           fetch_vaddr,
    // Outputs watched
    input wire logic                  sys_rst,
    input wire brs_pkg::brs_clk_cfg_t clk_cfg,
    input wire logic                  crystal_mode,
    input wire brs_pkg::brs_fetch_t   fetch
);
    import brs_pkg::*;
    logic [BRS_CNT_W-1:0] hold_q;
    // Cycles of reset held while supply is good
    always_ff @(posedge clk) begin
        if (rst || !sys_rst || !supply_good)
            hold_q <= '0;
        else
            hold_q <= hold_q + 1'b1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    supply_hold_a: assert property ($fell(supply_good) |->
        ##[1:4] sys_rst) else $error("reset not raised on supply loss");
    strap_read_a: assert property ($fell(sys_rst) |->
        crystal_mode == !oscillator_select_strap) else $error("bad mode");
    xtal_wait_a: assert property ($fell(sys_rst) && crystal_mode |->
        hold_q >= SETTLE_CYC) else $error("crystal release too early");
    ext_fast_a: assert property ($rose(supply_good) &&
        oscillator_select_strap |-> ##[1:4] !sys_rst) else $error("slow");
    pll_off_a: assert property ($fell(sys_rst) |->
        clk_cfg.pll_en == '0) else $error("pll enabled at release");
    clk_full_a: assert property ($fell(sys_rst) |->
        &clk_cfg.clk_gate_en && clk_cfg.clk_div == '0)
        else $error("clocks gated or divided");
    seg_map_a: assert property (fetch_vaddr[31:29] == 3'h5 |->
        fetch.uncached && fetch.untranslated && fetch.paddr ==
        {3'h0, fetch_vaddr[28:0]}) else $error("segment map wrong");
    boot_sel_a: assert property (fetch_vaddr == BRS_RESET_VADDR |->
        fetch.sel_zero) else $error("boot fetch not on select zero");
    cover property ($fell(sys_rst) && crystal_mode);
    cover property ($fell(sys_rst) && !crystal_mode);
    cover property (fetch.sel_zero);
endmodule : brs_checker
bind brs_sequencer brs_checker #(.SETTLE_CYC(SETTLE_CYC)) brs_checker_i (
    .clk(clk), .rst(rst), .supply_good(supply_good), .fetch(fetch),
    .oscillator_select_strap(oscillator_select_strap), .clk_cfg(clk_cfg),
    .fetch_vaddr(fetch_vaddr), .sys_rst(sys_rst), .crystal_mode(crystal_mode));

// ---- brs_partner.sv ----
// Pin-side model: supply monitor flag and source-select strap.
// Assumes the bench decides when power is good and what is fitted.
`timescale 1ns/1ps
module brs_partner (
    // Bench controls
    input  wire logic power_on,
    input  wire logic xtal_fitted,
    // Pins into the device
    output logic      supply_good,
    output logic      oscillator_select_strap
);
    // Strap tied low when a crystal is fitted
    assign oscillator_select_strap = ~xtal_fitted;
    assign supply_good             = power_on;
endmodule : brs_partner

// ---- tb_top.sv ----
// Self-checking bench for the boot reset sequencer.
// Assumes brs_partner drives the supply flag and strap pins.
`timescale 1ns/1ps
module tb_top;
    import brs_pkg::*;
    localparam int SC = 8;
    logic clk = 0, rst = 1, clk_en = 1, pwr = 0, xtal = 0;
    logic sg, strap, sys_rst, sel_p, xm;
    logic [31:0] va = '0, pc;
    brs_clk_cfg_t cfg;
    brs_fetch_t   fe;
    int bad_count = 0, num_checks = 0;
    always #4 clk = ~clk;
    brs_partner brs_partner_i (.power_on(pwr), .xtal_fitted(xtal),
        .supply_good(sg), .oscillator_select_strap(strap));
    brs_sequencer #(.SETTLE_CYC(SC)) brs_sequencer_i (.clk(clk), .rst(rst),
        .clk_en(clk_en), .supply_good(sg), .oscillator_select_strap(strap),
        .fetch_vaddr(va), .sys_rst(sys_rst), .sys_clk_sel_primary(sel_p),
        .clk_cfg(cfg), .boot_pc(pc), .crystal_mode(xm), .fetch(fe));
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic boot(logic x, output int n);
        @(negedge clk) pwr = 0;
        xtal = x;
        repeat (6) @(negedge clk);
        pwr = 1;
        n = 0;
        while (sys_rst !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
    endtask : boot
    task automatic t_ext;
        int n;
        boot(1'b0, n);
        chk("ext delay", 1, 32'(n >= 3 && n <= 4));
        chk("crystal_mode", 0, 32'(xm));
        chk("clk_sel", 1, 32'(sel_p));
        chk("pll_en", 0, 32'(cfg.pll_en));
        chk("gate_en", 32'hffff, 32'(cfg.clk_gate_en));
        chk("div_zero", 1, 32'(cfg.clk_div == '0));
        chk("boot_pc", 32'ha000_0000, pc);
    endtask : t_ext
    task automatic t_drop;
        int n;
        @(negedge clk) pwr = 0;
        n = 0;
        while (sys_rst !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk("drop delay", 1, 32'(n <= 4));
    endtask : t_drop
    task automatic t_xtal;
        int n;
        boot(1'b1, n);
        chk("xtal delay", 1, 32'(n >= SC + 2 && n <= SC + 5));
        chk("crystal_mode", 1, 32'(xm));
    endtask : t_xtal
    task automatic t_stall;
        int n;
        @(negedge clk) pwr = 0;
        repeat (6) @(negedge clk);
        pwr = 1;
        repeat (5) @(negedge clk);
        clk_en = 0;
        repeat (SC) @(negedge clk);
        chk("stall rst", 1, 32'(sys_rst));
        clk_en = 1;
        n = 5 + SC;
        while (sys_rst !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk("stall", 1, 32'(n >= 2*SC + 2 && n <= 2*SC + 5));
    endtask : t_stall
    task automatic t_fetch;
        logic [31:0] v [4] = '{32'ha000_0000, 32'ha3ff_fffc,
                               32'ha400_0000, 32'hbfff_ffff};
        for (int i = 0; i < 4; i++) begin
            @(negedge clk) va = v[i];
            #1;
            chk("vaddr", v[i], fe.vaddr);
            chk("paddr", v[i] - 32'ha000_0000, fe.paddr);
            chk("uncached", 1, 32'(fe.uncached && fe.untranslated));
            chk("sel_zero", 32'(i < 2), 32'(fe.sel_zero));
        end
    endtask : t_fetch
    task automatic complete_run;
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        repeat (4) @(negedge clk);
        rst = 0;
        t_ext();
        t_drop();
        t_xtal();
        t_stall();
        t_fetch();
        complete_run();
    end
    initial begin
        #20000;
        bad_count++;
        complete_run();
    end
endmodule : tb_top
